// file: src/rsic_counter.sv
`timescale 1ns/1ps
module rsic_counter #(
   parameter int WIDTH = 8
) (
   // clock and control
   input wire logic i_core_clk,
   input wire logic i_clear,
   input wire logic i_run,
   input wire logic [WIDTH-1:0] i_last,
   // status
   output logic [WIDTH-1:0] o_count,
   output logic o_done
);
   logic [WIDTH-1:0] cnt_reg;

   always_ff @(posedge i_core_clk) begin
      if (i_clear) begin
         cnt_reg <= '0;
      end else if (i_run && cnt_reg != i_last) begin
         cnt_reg <= cnt_reg + 1'b1;
      end
   end

   assign o_count = cnt_reg;
   assign o_done = (cnt_reg == i_last);
endmodule : rsic_counter

// file: src/rsic_pkg.sv
package rsic_pkg;
   // ----------------------------------------
   // init sequence states
   // ----------------------------------------
   typedef enum logic [3:0] {
      RSIC_ST_RESET = 4'h0,
      RSIC_ST_SELF_TEST = 4'h1,
      RSIC_ST_BUS_TEST = 4'h2,
      RSIC_ST_RUN = 4'h3,
      RSIC_ST_HALT = 4'h4,
      RSIC_ST_FLOAT = 4'h5
   } rsic_state_t;

   // ----------------------------------------
   // widths and counts
   // ----------------------------------------
   localparam int RSIC_SYNC_STAGES = 2;
   localparam int RSIC_AD_WIDTH = 32;
   localparam int RSIC_TEST_COUNT = 4;
   localparam int RSIC_TEST_CYCLES = 16;
   localparam int RSIC_BUS_TEST_CYCLES = 8;
   localparam logic [31:0] RSIC_AD_IDLE = 32'h0000_0000;
   // power-up and warm reset minimum hold, in clock cycles (board side)
   localparam int RSIC_PWRUP_RESET_CYCLES = 10000;
   localparam int RSIC_WARM_RESET_CYCLES = 15;
endpackage : rsic_pkg

// file: src/rsic_reset_init.sv
`timescale 1ns/1ps
// Contract
// [RULE1] core and bus share one clock and every input and output moves on its rising edge.
// [RULE2] during reset the address/data bus and control outputs sit idle.
// [RULE3] during reset only the float strap, self-test select and hold request are looked at.
// [RULE4] the reset input passes through a synchroniser before it acts.
// [RULE5] the board holds reset at least 10000 clocks at power-up; the testbench board holds it 12 clocks.
// [RULE6] the board should hold a warm reset at least 15 clocks.
// [RULE7] self-test select is sampled at the end of reset.
// [RULE8] with self-test selected, internal self-test runs, then the bus confidence test.
// [RULE9] without self-test selected, only the bus confidence test runs.
// [RULE10] fail is asserted at reset start and toggles per test during self-test.
// [RULE11] on a pass fail drops and user code starts.
// [RULE12] on a failure fail is asserted and execution halts.
// [RULE13] float strap low at end of reset stops the clocks and floats every output.
// [RULE14] a hold request is granted in reset, while halted and in normal running; the code refuses it in running while i_core_atomic is high.
// [RULE15] the reset synchroniser has two or more stages and releases only when synchronised.
module rsic_reset_init
   import rsic_pkg::*;
#(
   parameter int AD_WIDTH = RSIC_AD_WIDTH,
   parameter int TEST_COUNT = RSIC_TEST_COUNT,
   parameter int TEST_CYCLES = RSIC_TEST_CYCLES,
   parameter int BUS_TEST_CYCLES = RSIC_BUS_TEST_CYCLES
) (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst,
   // straps and requests
   input wire logic i_self_test_select,
   input wire logic i_atomic_or_float_strap_n,
   input wire logic i_hold_req,
   // core side
   input wire logic i_core_bus_req,
   input wire logic [AD_WIDTH-1:0] i_core_ad,
   input wire logic i_core_atomic,
   input wire logic [TEST_COUNT-1:0] i_test_fail,
   input wire logic i_bus_test_fail,
   // bus outputs
   output logic [AD_WIDTH-1:0] o_ad,
   output logic o_ad_oe,
   output logic o_addr_strobe_n,
   output logic o_ctrl_oe,
   output logic o_atomic_n,
   output logic o_atomic_oe,
   output logic o_bus_grant_ack,
   output logic o_bus_grant_ack_oe,
   // status
   output logic o_fail_n,
   output logic o_fail_oe,
   output logic o_core_run,
   output logic o_core_clk_en,
   output logic o_all_outputs_float_mode,
   output logic [3:0] o_state
);
   // ----------------------------------------
   // reset synchroniser
   // ----------------------------------------
   logic rst_sync;

   // only the last stage is read; the raw pin may move at any time
   rsic_sync #(
      .STAGES(RSIC_SYNC_STAGES)
   ) u_rst_sync (
      .i_core_clk(i_core_clk),
      .i_level(i_rst),
      .o_level(rst_sync)
   ); // RULE4 RULE15

   // ----------------------------------------
   // state and counters
   // ----------------------------------------
   rsic_state_t state_reg;
   rsic_state_t state_next;
   logic [7:0] test_idx_reg;
   logic [7:0] test_idx_next;
   logic fail_reg;
   logic fail_next;
   logic any_fail_reg;
   logic any_fail_next;
   logic self_test_select_reg;
   logic float_reg;
   logic hold_ack_reg;
   logic [AD_WIDTH-1:0] ad_reg;
   logic ad_oe_reg;
   logic strobe_n_reg;
   logic ctrl_oe_reg;
   logic atomic_n_reg;
   logic run_reg;
   logic clk_en_reg;
   logic fail_n_reg;
   logic pins_oe_reg;
   logic [15:0] phase_cnt;
   logic phase_done;
   logic phase_clear;
   logic [15:0] phase_last;

   // ----------------------------------------
   // state decode
   // ----------------------------------------
   wire in_reset = rst_sync;
   wire in_self = (state_reg == RSIC_ST_SELF_TEST);
   wire in_bus = (state_reg == RSIC_ST_BUS_TEST);
   wire in_run = (state_reg == RSIC_ST_RUN);
   wire in_halt = (state_reg == RSIC_ST_HALT);
   wire in_float = (state_reg == RSIC_ST_FLOAT);
   wire last_test = (test_idx_reg == 8'(TEST_COUNT - 1));
   wire cur_test_fail = i_test_fail[test_idx_reg[$clog2(TEST_COUNT > 1 ? TEST_COUNT : 2)-1:0]];
   wire reset_end = (state_reg == RSIC_ST_RESET) && !in_reset;
   // hold refused while an atomic sequence drives the lock pin
   wire hold_ok = (in_reset || in_halt || in_run || (state_reg == RSIC_ST_RESET))
      && !(in_run && i_core_atomic); // RULE14
   wire drive_bus = in_run && !hold_ack_reg && !in_reset;

   // ----------------------------------------
   // phase timer
   // ----------------------------------------
   // one timer paces both test phases, cleared between tests
   assign phase_clear = in_reset || reset_end || (in_self && phase_done)
      || (state_reg == RSIC_ST_RUN);
   assign phase_last = in_self ? 16'(TEST_CYCLES - 1) : 16'(BUS_TEST_CYCLES - 1);

   rsic_counter #(
      .WIDTH(16)
   ) u_phase (
      .i_core_clk(i_core_clk),
      .i_clear(phase_clear),
      .i_run(in_self || in_bus),
      .i_last(phase_last),
      .o_count(phase_cnt),
      .o_done(phase_done)
   );

   // ----------------------------------------
   // sequence decode
   // ----------------------------------------
   always_comb begin
      state_next = state_reg;
      test_idx_next = test_idx_reg;
      fail_next = fail_reg;
      any_fail_next = any_fail_reg;
      case (state_reg)
         RSIC_ST_RESET: begin
            fail_next = 1'b1; // RULE10
            any_fail_next = 1'b0;
            test_idx_next = 8'h00;
            if (!in_reset) begin
               if (!i_atomic_or_float_strap_n) begin
                  state_next = RSIC_ST_FLOAT; // RULE13
               end else if (i_self_test_select) begin
                  state_next = RSIC_ST_SELF_TEST; // RULE7 RULE8
               end else begin
                  state_next = RSIC_ST_BUS_TEST; // RULE9
               end
            end
         end
         RSIC_ST_SELF_TEST: begin
            if (phase_done) begin
               fail_next = ~fail_reg; // RULE10
               any_fail_next = any_fail_reg | cur_test_fail;
               test_idx_next = test_idx_reg + 8'h01;
               if (last_test) begin
                  state_next = RSIC_ST_BUS_TEST; // RULE8
               end
            end
         end
         RSIC_ST_BUS_TEST: begin
            if (phase_done) begin
               if (any_fail_reg || i_bus_test_fail) begin
                  fail_next = 1'b1; // RULE12
                  state_next = RSIC_ST_HALT;
               end else begin
                  fail_next = 1'b0; // RULE11
                  state_next = RSIC_ST_RUN;
               end
            end
         end
         RSIC_ST_RUN: begin
            // user code runs until the next reset
         end
         RSIC_ST_HALT: begin
            // execution stopped after a failed test
         end
         RSIC_ST_FLOAT: begin
            // clocks stopped, pins floating
         end
         default: begin
            state_next = RSIC_ST_RESET;
         end
      endcase
   end

   // ----------------------------------------
   // sequence registers
   // ----------------------------------------
   always_ff @(posedge i_core_clk) begin // RULE1
      if (in_reset) begin
         state_reg <= RSIC_ST_RESET;
         test_idx_reg <= 8'h00;
      end else begin
         state_reg <= state_next;
         test_idx_reg <= test_idx_next;
      end
   end

   // ----------------------------------------
   // fail level and sticky self-test result
   // ----------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (in_reset) begin
         fail_reg <= 1'b1; // RULE10
         any_fail_reg <= 1'b0;
      end else begin
         fail_reg <= fail_next;
         any_fail_reg <= any_fail_next;
      end
   end

   // ----------------------------------------
   // strap capture
   // ----------------------------------------
   // taken only at the release edge
   always_ff @(posedge i_core_clk) begin
      if (in_reset) begin
         self_test_select_reg <= 1'b0;
         float_reg <= 1'b0;
         pins_oe_reg <= 1'b1;
      end else if (reset_end) begin
         self_test_select_reg <= i_self_test_select; // RULE7
         float_reg <= !i_atomic_or_float_strap_n; // RULE13
         pins_oe_reg <= i_atomic_or_float_strap_n; // RULE13
      end
   end

   // ----------------------------------------
   // hold handshake
   // ----------------------------------------
   // a grant already given stands while the request stays up, except in float mode
   wire hold_ack_next = !in_float && i_hold_req && (hold_ok || hold_ack_reg); // RULE14 RULE3

   always_ff @(posedge i_core_clk) begin
      hold_ack_reg <= hold_ack_next;
   end

   // ----------------------------------------
   // output decode
   // ----------------------------------------
   // idle bus levels whenever the core does not own the bus
   wire [AD_WIDTH-1:0] ad_next = drive_bus ? i_core_ad : AD_WIDTH'(RSIC_AD_IDLE); // RULE3
   wire strobe_n_next = !(drive_bus && i_core_bus_req); // RULE2
   wire atomic_n_next = !(drive_bus && i_core_atomic);
   // drivers let go in float mode, for a hold, and at once for a request seen in reset
   wire bus_oe_next = !in_float && !hold_ack_reg && !(in_reset && i_hold_req); // RULE2
   wire run_next = in_run && !in_reset; // RULE11
   // clocks stop only in float mode
   wire clk_en_next = !in_float || in_reset; // RULE13
   wire fail_n_next = in_reset ? 1'b0 : !fail_next; // RULE10

   // ----------------------------------------
   // bus output registers
   // ----------------------------------------
   always_ff @(posedge i_core_clk) begin
      ad_reg <= ad_next;
      strobe_n_reg <= strobe_n_next;
      atomic_n_reg <= atomic_n_next;
   end

   always_ff @(posedge i_core_clk) begin
      ad_oe_reg <= bus_oe_next; // RULE2
      ctrl_oe_reg <= bus_oe_next;
   end

   // ----------------------------------------
   // status output registers
   // ----------------------------------------
   always_ff @(posedge i_core_clk) begin
      run_reg <= run_next; // RULE11
      clk_en_reg <= clk_en_next; // RULE13
      fail_n_reg <= fail_n_next; // RULE10
   end

   // ----------------------------------------
   // output ports
   // ----------------------------------------
   assign o_ad = ad_reg;
   assign o_ad_oe = ad_oe_reg;
   assign o_addr_strobe_n = strobe_n_reg;
   assign o_ctrl_oe = ctrl_oe_reg;
   assign o_atomic_n = atomic_n_reg;
   assign o_atomic_oe = ctrl_oe_reg;
   assign o_bus_grant_ack = hold_ack_reg;
   assign o_bus_grant_ack_oe = pins_oe_reg;
   assign o_fail_n = fail_n_reg;
   assign o_fail_oe = pins_oe_reg;
   assign o_core_run = run_reg;
   assign o_core_clk_en = clk_en_reg;
   assign o_all_outputs_float_mode = float_reg;
   assign o_state = state_reg;

   logic unused_ok;
   assign unused_ok = self_test_select_reg;
endmodule : rsic_reset_init

// file: src/rsic_sync.sv
`timescale 1ns/1ps
module rsic_sync #(
   parameter int STAGES = 2
) (
   // clock
   input wire logic i_core_clk,
   // level in and out
   input wire logic i_level,
   output logic o_level
);
   logic [STAGES-1:0] sync_reg;

   always_ff @(posedge i_core_clk) begin
      sync_reg <= {sync_reg[STAGES-2:0], i_level};
   end

   assign o_level = sync_reg[STAGES-1];
endmodule : rsic_sync

// file: testbench/rsic_board.sv
`timescale 1ns/1ps
module rsic_board (
   // clock and request
   input wire logic i_core_clk,
   input wire logic i_start,
   input wire logic [15:0] i_len,
   // reset to the device
   output logic o_rst
);
   // ----------------------------------------
   // reset hold timer, starts in reset
   // ----------------------------------------
   logic [15:0] cnt_reg = 16'h000C;
   always @(posedge i_core_clk) begin
      if (i_start) begin
         cnt_reg <= i_len;
      end else if (cnt_reg != 16'h0000) begin
         cnt_reg <= cnt_reg - 16'h0001;
      end
   end
   assign o_rst = (cnt_reg != 16'h0000);
endmodule : rsic_board

// file: testbench/rsic_reset_init_properties.sv
`timescale 1ns/1ps
module rsic_reset_init_properties
   import rsic_pkg::*;
#(
   parameter int AD_WIDTH = RSIC_AD_WIDTH,
   parameter int TEST_COUNT = RSIC_TEST_COUNT,
   parameter int TEST_CYCLES = RSIC_TEST_CYCLES,
   parameter int BUS_TEST_CYCLES = RSIC_BUS_TEST_CYCLES
) (
   // watched ports
   input wire logic i_core_clk, i_rst, i_self_test_select, i_hold_req, i_core_atomic,
   input wire logic [AD_WIDTH-1:0] o_ad,
   input wire logic o_ad_oe, o_addr_strobe_n, o_ctrl_oe, o_atomic_oe, o_bus_grant_ack,
   input wire logic o_bus_grant_ack_oe, o_fail_n, o_fail_oe, o_core_run, o_core_clk_en,
   input wire logic o_all_outputs_float_mode,
   input wire logic [3:0] o_state
);
   logic [2:0] rcnt_reg;
   logic [3:0] prev_reg;
   logic [7:0] scnt_reg;
   // reset length and time spent in the current state
   always_ff @(posedge i_core_clk) begin
      rcnt_reg <= !i_rst ? 3'h0 : (rcnt_reg == 3'h7 ? 3'h7 : rcnt_reg + 3'h1);
      prev_reg <= o_state;
      scnt_reg <= (o_state != prev_reg) ? 8'h01 : scnt_reg + 8'h01;
   end
   chk_reset_bus_idle: assert property (@(posedge i_core_clk)
      rcnt_reg >= 3'h4 |-> o_addr_strobe_n && o_ad == '0 && !o_core_run)
      else $error("bus active during reset");
   chk_reset_fail_low: assert property (@(posedge i_core_clk)
      rcnt_reg >= 3'h4 |-> !o_fail_n && o_state == 4'h0) else $error("fail high in reset");
   chk_sync_delay: assert property (@(posedge i_core_clk)
      $rose(i_rst) && o_state == 4'h3 |=> o_state == 4'h3) else $error("reset not synced");
   chk_release_move: assert property (@(posedge i_core_clk) disable iff (i_rst)
      $fell(i_rst) |-> ##[1:4] o_state != 4'h0) else $error("no start after reset");
   chk_path_select: assert property (@(posedge i_core_clk) disable iff (i_rst)
      prev_reg == 4'h0 && o_state inside {4'h1, 4'h2} |-> (o_state == 4'h1) == i_self_test_select)
      else $error("wrong test path");
   chk_selftest_len: assert property (@(posedge i_core_clk) disable iff (i_rst)
      prev_reg == 4'h1 && o_state == 4'h2 |-> scnt_reg == TEST_COUNT * TEST_CYCLES)
      else $error("self-test length wrong");
   chk_bustest_len: assert property (@(posedge i_core_clk) disable iff (i_rst)
      prev_reg == 4'h2 && o_state inside {4'h3, 4'h4} |-> scnt_reg == BUS_TEST_CYCLES)
      else $error("bus test length wrong");
   chk_pass_run: assert property (@(posedge i_core_clk) disable iff (i_rst)
      prev_reg == 4'h2 && o_state == 4'h3 |=> o_fail_n && o_core_run) else $error("no run");
   chk_fail_halt: assert property (@(posedge i_core_clk) disable iff (i_rst)
      prev_reg == 4'h4 && o_state == 4'h4 |-> !o_fail_n && !o_core_run) else $error("no halt");
   chk_float_all: assert property (@(posedge i_core_clk) disable iff (i_rst)
      prev_reg == 4'h5 && o_state == 4'h5 |-> !o_core_clk_en && o_all_outputs_float_mode
      && !o_ad_oe && !o_ctrl_oe && !o_atomic_oe && !o_fail_oe && !o_bus_grant_ack_oe)
      else $error("float mode incomplete");
   chk_hold_grant: assert property (@(posedge i_core_clk) i_hold_req && (rcnt_reg >= 3'h4
      || o_state == 4'h4 || (o_state == 4'h3 && !i_core_atomic)) |=> o_bus_grant_ack)
      else $error("hold not granted");
endmodule : rsic_reset_init_properties

bind rsic_reset_init rsic_reset_init_properties #(.AD_WIDTH(AD_WIDTH),
   .TEST_COUNT(TEST_COUNT), .TEST_CYCLES(TEST_CYCLES), .BUS_TEST_CYCLES(BUS_TEST_CYCLES))
   i_rsic_reset_init_properties (.i_core_clk, .i_rst, .i_self_test_select, .i_hold_req,
   .i_core_atomic, .o_ad, .o_ad_oe, .o_addr_strobe_n, .o_ctrl_oe, .o_atomic_oe,
   .o_bus_grant_ack, .o_bus_grant_ack_oe, .o_fail_n, .o_fail_oe, .o_core_run,
   .o_core_clk_en, .o_all_outputs_float_mode, .o_state);

// file: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import rsic_pkg::*;
   typedef struct {
      logic st, fl;
      logic [3:0] tf;
      logic bf;
      logic [3:0] fst;
      logic run, fn;
      int tog;
   } rsic_row_t;
   logic clk, rst, self_test_select, strap_n, hold, breq, atom, bfail, start, fn_prev;
   logic [3:0] tfail;
   logic [3:0] state;
   logic [31:0] cad;
   logic [31:0] ad;
   logic [15:0] len;
   logic ad_oe, as_n, grant, fail_n, run, clk_en, atom_n;
   int bad_count, total_checks, tog_cnt;
   rsic_row_t rows [6] = '{
      '{1'b1, 1'b1, 4'h0, 1'b0, 4'h3, 1'b1, 1'b1, 4},
      '{1'b0, 1'b1, 4'h0, 1'b0, 4'h3, 1'b1, 1'b1, 0},
      '{1'b1, 1'b1, 4'h2, 1'b0, 4'h4, 1'b0, 1'b0, -1},
      '{1'b0, 1'b1, 4'hF, 1'b0, 4'h3, 1'b1, 1'b1, 0},
      '{1'b0, 1'b1, 4'h0, 1'b1, 4'h4, 1'b0, 1'b0, 0},
      '{1'b1, 1'b0, 4'h0, 1'b0, 4'h5, 1'b0, 1'b0, -1}
   };
   rsic_board i_rsic_board (.i_core_clk(clk), .i_start(start), .i_len(len), .o_rst(rst));
   rsic_reset_init i_rsic_reset_init (
      .i_core_clk(clk), .i_rst(rst), .i_self_test_select(self_test_select),
      .i_atomic_or_float_strap_n(strap_n), .i_hold_req(hold), .i_core_bus_req(breq),
      .i_core_ad(cad), .i_core_atomic(atom), .i_test_fail(tfail), .i_bus_test_fail(bfail),
      .o_ad(ad), .o_ad_oe(ad_oe), .o_addr_strobe_n(as_n), .o_ctrl_oe(), .o_atomic_n(atom_n),
      .o_atomic_oe(), .o_bus_grant_ack(grant), .o_bus_grant_ack_oe(), .o_fail_n(fail_n),
      .o_fail_oe(), .o_core_run(run), .o_core_clk_en(clk_en),
      .o_all_outputs_float_mode(), .o_state(state));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // fail toggles seen during the tests
   always @(posedge clk) begin
      if ((state == 4'h1 || state == 4'h2) && fail_n !== fn_prev)
         tog_cnt++;
      fn_prev = fail_n;
   end
   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         $display("[ERR] %s expected %0h seen %0h", name, exp, got);
         bad_count++;
      end
   endtask : chk
   task end_of_test;
      $display("checks %0d errors %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_of_test
   // warm reset of n cycles, returns after release
   task pulse(input logic [15:0] n);
      start <= 1'b1;
      len <= n;
      tog_cnt = 0;
      @(posedge clk);
      start <= 1'b0;
      @(posedge clk);
      while (rst)
         @(posedge clk);
   endtask : pulse
   task settle;
      for (int n = 0; n < 300 && !(state inside {4'h3, 4'h4, 4'h5}); n++)
         @(posedge clk);
      repeat (2) @(posedge clk);
   endtask : settle
   initial begin
      start = 1'b0;
      len = 16'h0000;
      {self_test_select, strap_n, hold, breq, atom, bfail, fn_prev} = 7'h48;
      tfail = 4'h0;
      cad = 32'h0000_0000;
      repeat (14) @(posedge clk);
      foreach (rows[k]) begin
         self_test_select <= rows[k].st;
         strap_n <= rows[k].fl;
         tfail <= rows[k].tf;
         bfail <= rows[k].bf;
         pulse(16'h000F);
         settle();
         chk("state", rows[k].fst, state);
         chk("core_run", rows[k].run, run);
         chk("clk_en", rows[k].fst != 4'h5, clk_en);
         if (rows[k].fst != 4'h5)
            chk("fail_n", rows[k].fn, fail_n);
         if (rows[k].tog >= 0)
            chk("toggles", rows[k].tog, tog_cnt);
      end
      // hold refused under atomic lock, granted after
      {self_test_select, strap_n} <= 2'h1;
      pulse(16'h000F);
      settle();
      atom <= 1'b1;
      hold <= 1'b1;
      repeat (3) @(posedge clk);
      chk("grant_atomic", 1'b0, grant);
      chk("atomic_n", 1'b0, atom_n);
      atom <= 1'b0;
      repeat (3) @(posedge clk);
      chk("grant_run", 1'b1, grant);
      chk("ad_oe_hold", 1'b0, ad_oe);
      // long reset with hold and core traffic
      breq <= 1'b1;
      cad <= 32'hA5A5_5A5A;
      start <= 1'b1;
      len <= 16'h2710;
      @(posedge clk);
      start <= 1'b0;
      repeat (8) @(posedge clk);
      chk("grant_reset", 1'b1, grant);
      chk("strobe_reset", 1'b1, as_n);
      chk("ad_reset", 32'h0000_0000, ad);
      chk("fail_reset", 1'b0, fail_n);
      hold <= 1'b0;
      repeat (10000) @(posedge clk);
      settle();
      chk("state_after", 4'h3, state);
      chk("ad_run", 32'hA5A5_5A5A, ad);
      chk("strobe_run", 1'b0, as_n);
      end_of_test();
   end
   initial begin
      #120000;
      bad_count++;
      end_of_test();
   end
endmodule : tb_top
